// file: indirect_io_pkg.sv
/*
 Shared constants for the indirect IO register window: IO offsets, field
 positions, reset values and target encodings.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package indirect_io_pkg;
	localparam logic [2:0]  ADDR_OFFSET        = 3'h0;
	localparam logic [2:0]  WINDOW_OFFSET      = 3'h4;
	localparam logic [31:0] ADDR_RESET         = 32'h0000_0000;
	localparam logic [31:0] WINDOW_RESET       = 32'h0000_0000;
	localparam int          OFFSET_LSB         = 2;
	localparam int          OFFSET_MSB         = 31;
	localparam int          TARGET_LSB         = 0;
	localparam int          TARGET_MSB         = 1;
	localparam logic [1:0]  TARGET_REGS        = 2'h0;
	localparam logic [1:0]  TARGET_TABLE       = 2'h1;
	localparam logic [3:0]  BYTES_FULL         = 4'hf;
	localparam logic [3:0]  BYTES_NONE         = 4'h0;
endpackage
`default_nettype wire

// file: io_write_qualifier.sv
/*
 Small decoder: classifies a host IO cycle by port and width.
 Assumes byte enables and address arrive on the core clock.
*/
`default_nettype none
module io_write_qualifier (
	input  wire logic [2:0] io_addr_in,
	input  wire logic [3:0] io_be_in,
	output logic            hit_addr_out,
	output logic            hit_window_out,
	output logic            full_out
);
	// ----------------------------------------
	// Port and width decode
	// ----------------------------------------
	assign hit_addr_out   = (io_addr_in[2] == indirect_io_pkg::ADDR_OFFSET[2]);
	assign hit_window_out = (io_addr_in[2] == indirect_io_pkg::WINDOW_OFFSET[2]);
	assign full_out       = (io_be_in == indirect_io_pkg::BYTES_FULL);
endmodule
`default_nettype wire

// file: indirect_io_register_window.sv
/*
 Indirect IO access port: an address register and a data window that forward
 host IO cycles into the internal register space or the translation table.
 Assumes a single core clock; the internal side answers with a one-cycle
 done pulse, and the host holds a cycle until io_ready_out.
*/
`default_nettype none
module indirect_io_register_window (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        io_req_in,
	input  wire logic        io_write_in,
	input  wire logic [2:0]  io_addr_in,
	input  wire logic [3:0]  io_be_in,
	input  wire logic [31:0] io_wdata_in,
	output logic             io_ready_out,
	output logic [31:0]      io_rdata_out,
	output logic             int_req_out,
	output logic             int_write_out,
	output logic             int_table_out,
	output logic [29:0]      int_offset_out,
	output logic [31:0]      int_wdata_out,
	output logic [3:0]       int_be_out,
	input  wire logic        int_done_in,
	input  wire logic [31:0] int_rdata_in
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [31:0] addr;
		logic [31:0] window;
		logic        ready;
		logic [31:0] rdata;
		logic        ireq;
		logic        iwrite;
		logic        itable;
		logic [29:0] ioffset;
		logic [31:0] iwdata;
		logic [3:0]  ibe;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic hit_addr;
	logic hit_window;
	logic full;

	io_write_qualifier qual (
		.io_addr_in     (io_addr_in),
		.io_be_in       (io_be_in),
		.hit_addr_out   (hit_addr),
		.hit_window_out (hit_window),
		.full_out       (full)
	);

	// ----------------------------------------
	// Cycle decode
	// ----------------------------------------
	logic        take_addr;
	logic        take_window;
	logic        take_other;
	logic        addr_load;
	logic [1:0]  held_target;
	logic        held_table;
	logic [29:0] held_offset;

	assign take_addr   = io_req_in && hit_addr;
	// A window cycle with no byte enabled has nothing to forward
	assign take_window = io_req_in && hit_window && (io_be_in != indirect_io_pkg::BYTES_NONE);
	assign take_other  = io_req_in && !take_addr && !take_window;
	// Only a full dword write may change the address port
	assign addr_load   = take_addr && io_write_in && full;
	assign held_target = s_q.addr[indirect_io_pkg::TARGET_MSB:indirect_io_pkg::TARGET_LSB];
	assign held_table  = (held_target == indirect_io_pkg::TARGET_TABLE);
	assign held_offset = s_q.addr[indirect_io_pkg::OFFSET_MSB:indirect_io_pkg::OFFSET_LSB];

	// ----------------------------------------
	// Completion
	// ----------------------------------------
	logic        wait_done;
	logic        read_done;
	logic        write_done;

	assign wait_done  = (s_q.phase == ST_WAIT) && int_done_in;
	assign read_done  = wait_done && !s_q.iwrite;
	assign write_done = wait_done && s_q.iwrite;

	// ----------------------------------------
	// Byte lanes
	// ----------------------------------------
	logic [31:0] read_lanes;
	logic [31:0] write_lanes;

	// Disabled lanes keep the byte the window already holds
	for (genvar lane = 0; lane < 4; lane++) begin : g_lane
		assign read_lanes[8*lane +: 8]  = s_q.ibe[lane] ? int_rdata_in[8*lane +: 8] : s_q.window[8*lane +: 8];
		assign write_lanes[8*lane +: 8] = s_q.ibe[lane] ? s_q.iwdata[8*lane +: 8] : s_q.window[8*lane +: 8];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.ready = 1'b0;
		unique case (s_q.phase)
			ST_IDLE: begin
				if (take_addr) begin
					if (addr_load) begin
						s_d.addr = io_wdata_in;
					end
					if (!io_write_in) begin
						s_d.rdata = s_q.addr;
					end
					s_d.ready = 1'b1;
					s_d.phase = ST_DONE;
				end else if (take_window) begin
					s_d.ireq    = 1'b1;
					s_d.iwrite  = io_write_in;
					s_d.ioffset = held_offset;
					// Reads always go to registers; writes follow the target field
					s_d.itable  = io_write_in && held_table;
					s_d.iwdata  = io_wdata_in;
					s_d.ibe     = io_be_in;
					s_d.phase   = ST_WAIT;
				end else if (take_other) begin
					s_d.rdata = 32'h0000_0000;
					s_d.ready = 1'b1;
					s_d.phase = ST_DONE;
				end
			end
			ST_WAIT: begin
				if (wait_done) begin
					s_d.ireq  = 1'b0;
					s_d.ready = 1'b1;
					s_d.phase = ST_DONE;
				end
				if (read_done) begin
					s_d.window = read_lanes;
					s_d.rdata  = read_lanes;
				end
				if (write_done) begin
					s_d.window = write_lanes;
				end
			end
			ST_DONE: begin
				s_d.phase = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q.phase   <= ST_IDLE;
			s_q.addr    <= indirect_io_pkg::ADDR_RESET;
			s_q.window  <= indirect_io_pkg::WINDOW_RESET;
			s_q.ready   <= 1'b0;
			s_q.rdata   <= 32'h0000_0000;
			s_q.ireq    <= 1'b0;
			s_q.iwrite  <= 1'b0;
			s_q.itable  <= 1'b0;
			s_q.ioffset <= 30'h0000_0000;
			s_q.iwdata  <= 32'h0000_0000;
			s_q.ibe     <= 4'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign io_ready_out   = s_q.ready;
	assign io_rdata_out   = s_q.rdata;
	assign int_req_out    = s_q.ireq;
	assign int_write_out  = s_q.iwrite;
	assign int_table_out  = s_q.itable;
	assign int_offset_out = s_q.ioffset;
	assign int_wdata_out  = s_q.iwdata;
	assign int_be_out     = s_q.ibe;
endmodule
`default_nettype wire

// file: io_window_asserts.sv
/* Checker for the indirect window block.
 Bound to its top module; sees its ports only. */
`default_nettype none
module io_window_asserts (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic        io_req_in,
	input wire logic        io_write_in,
	input wire logic [2:0]  io_addr_in,
	input wire logic [3:0]  io_be_in,
	input wire logic        io_ready_out,
	input wire logic        int_req_out,
	input wire logic        int_write_out,
	input wire logic        int_table_out,
	input wire logic [29:0] int_offset_out,
	input wire logic [3:0]  int_be_out,
	input wire logic        int_done_in
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_port_local: assert property ($rose(io_req_in) && !io_addr_in[2] |=> io_ready_out && !int_req_out)
		else $error("address port slow");
	a_win_fwd: assert property ($rose(io_req_in) && io_addr_in[2] && io_be_in == 4'hf |=> int_req_out
		&& int_write_out == $past(io_write_in)) else $error("window not forwarded");
	a_be_fwd: assert property ($rose(io_req_in) && io_addr_in[2] && io_be_in != 4'h0
		|=> int_be_out == $past(io_be_in)) else $error("byte enables not forwarded");
	a_read_regs: assert property (int_req_out && !int_write_out |-> !int_table_out)
		else $error("read went to table");
	a_done_ends: assert property (int_req_out && int_done_in |=> io_ready_out && !int_req_out)
		else $error("no completion");
	a_no_early: assert property (int_req_out && !int_done_in |=> !io_ready_out && int_req_out)
		else $error("early completion");
	a_offset_held: assert property (int_req_out && !int_done_in |=> $stable(int_offset_out))
		else $error("offset moved");
	a_ready_pulse: assert property (io_ready_out |=> !io_ready_out)
		else $error("ready too long");
	a_no_stray: assert property (!io_req_in |=> !$rose(int_req_out))
		else $error("stray request");
	c_write: cover property (int_req_out && int_write_out && int_done_in);
	c_narrow: cover property (int_req_out && int_be_out != 4'hf && int_done_in);
	c_read: cover property (int_req_out && !int_write_out && int_done_in);
	c_table: cover property (int_table_out && int_done_in);
endmodule
bind indirect_io_register_window io_window_asserts chk (.*);
`default_nettype wire

// file: int_space_model.sv
/* Internal register space model.
 Answers a request with a done pulse lat_in+1 cycles after req_in rises; table writes are dropped. */
`default_nettype none
module int_space_model (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic        req_in,
	input wire logic        write_in,
	input wire logic        table_in,
	input wire logic [1:0]  offset_in,
	input wire logic [31:0] wdata_in,
	input wire logic [1:0]  lat_in,
	output logic            done_out,
	output logic [31:0]     rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] regs [4];
	logic [1:0]  n;
	logic        hit;
	always @(posedge clk_in or posedge reset_in) begin
		done_out <= 1'b0;
		rdata_out <= ~rdata_out;
		n <= n + 2'h1;
		if (reset_in) begin
			regs <= '{default: '0};
			rdata_out <= '0;
			hit <= 1'b0;
		end else if (!req_in) begin
			n <= 2'h0;
			hit <= 1'b0;
		end else if (!hit && n == lat_in) begin
			done_out <= 1'b1;
			hit <= 1'b1;
			rdata_out <= regs[offset_in];
			if (write_in && !table_in) regs[offset_in] <= wdata_in;
		end
	end
endmodule
`default_nettype wire

// file: indirect_io_register_window_tb.sv
/* Bench for the indirect window with a reference model.
 Needs the design, its checker and the internal space model. */
`default_nettype none
module indirect_io_register_window_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, reset_in = 1, req = 0, wr = 0, idone, rdy, ireq, iwr, itbl;
	logic [2:0] adr = '0;
	logic [3:0] be = '0, ibe;
	logic [31:0] wd = '0, rd, ird, iwd, r, ad, d, m [4];
	logic [29:0] ioff;
	logic [1:0] lat = '0;
	int errors = 0, compares = 0, cyc = 0;
	always #10 clk_in = ~clk_in;
	indirect_io_register_window DUT (.clk_in(clk_in), .reset_in(reset_in), .io_req_in(req), .io_write_in(wr),
		.io_addr_in(adr), .io_be_in(be), .io_wdata_in(wd), .io_ready_out(rdy), .io_rdata_out(rd), .int_req_out(ireq),
		.int_write_out(iwr), .int_table_out(itbl), .int_offset_out(ioff), .int_wdata_out(iwd), .int_be_out(ibe),
		.int_done_in(idone), .int_rdata_in(ird));
	int_space_model far (.clk_in(clk_in), .reset_in(reset_in), .req_in(ireq), .write_in(iwr), .table_in(itbl),
		.offset_in(ioff[1:0]), .wdata_in(iwd), .lat_in(lat), .done_out(idone), .rdata_out(ird));
	task end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			end_of_test;
		end
	end
	task chk(string s, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task io(logic w, logic [2:0] a, logic [3:0] b, logic [31:0] v);
		int k;
		k = 0;
		req = 1'b1;
		wr = w;
		adr = a;
		be = b;
		wd = v;
		lat = 2'($urandom);
		@(negedge clk_in);
		while (rdy !== 1'b1 && k < 20) begin
			@(negedge clk_in);
			k++;
		end
		chk("ready", 1, rdy);
		r = rd;
		req = 1'b0;
		@(negedge clk_in);
	endtask
	initial begin
		logic [1:0] t, o;
		void'($urandom(32'h1372));
		m = '{default: '0};
		repeat (4) @(negedge clk_in);
		reset_in = 1'b0;
		io(0, 3'h0, 4'hf, '0);
		chk("addr reset", 0, r);
		io(0, 3'h4, 4'hf, '0);
		chk("window reset", 0, r);
		for (int i = 0; i < 12; i++) begin
			t = 2'(i);
			o = 2'($urandom);
			ad = $urandom;
			ad[3:0] = {o, t};
			d = $urandom;
			io(1, 3'h0, 4'hf, ad);
			io(1, 3'h2, 4'hc, ~ad);
			io(0, 3'h0, 4'hf, '0);
			chk("addr", ad, r);
			io(1, 3'h4, 4'hf, d);
			if (t != 2'h1) m[o] = d;
			io(0, 3'h4, 4'hf, '0);
			if (t != 2'h1) chk("window", m[o], r);
			io(0, 3'h6, 4'hc, '0);
			if (t != 2'h1) chk("narrow", m[o] >> 16, r >> 16);
			io(1, 3'h0, 4'hf, {ad[31:2], 2'h0});
			io(0, 3'h4, 4'hf, '0);
			chk("table dropped", m[o], r);
		end
		end_of_test;
	end
endmodule
`default_nettype wire
